// >>> src/pmd_pkg.sv
package pmd_pkg;

    localparam int unsigned ADDR_W        = 16;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned FLASH_KB_MIN  = 1;
    localparam int unsigned FLASH_KB_MAX  = 4;
    localparam int unsigned FLASH_KB_DEF  = 4;
    localparam int unsigned INFO_BYTES    = 128;
    localparam int unsigned INFO_AW       = 7;

    localparam logic [7:0]  BLANK_BYTE    = 8'hFF;

    // Fixed low-space layout, identical for every flash size.
    localparam logic [15:0] OPT_LO        = 16'h0000;
    localparam logic [15:0] RESET_VEC     = 16'h0002;
    localparam logic [15:0] WDT_VEC       = 16'h0004;
    localparam logic [15:0] ILL_TRAP_VEC  = 16'h0006;
    localparam logic [15:0] IRQ_VEC_LO    = 16'h0008;
    localparam logic [15:0] IRQ_VEC_HI    = 16'h0037;
    localparam logic [15:0] RSVD_LO       = 16'h0038;
    localparam logic [15:0] RSVD_HI       = 16'h0039;
    localparam logic [15:0] OSC_TRAP_LO   = 16'h003A;
    localparam logic [15:0] OSC_TRAP_HI   = 16'h003D;
    localparam logic [15:0] CODE_START    = 16'h003E;

    localparam logic [15:0] INFO_LO       = 16'hFE00;
    localparam logic [15:0] INFO_HI       = 16'hFF7F;
    localparam logic [15:0] INFO_OPT_HI   = 16'hFE3F;
    localparam logic [15:0] PART_LO       = 16'hFE40;
    localparam logic [15:0] PART_HI       = 16'hFE53;
    localparam logic [15:0] INFO_RSVD_LO  = 16'hFE54;
    localparam logic [15:0] INFO_RSVD_HI  = 16'hFE5F;
    localparam logic [15:0] CAL_LO        = 16'hFE60;
    localparam logic [15:0] CAL_HI        = 16'hFE7F;

    localparam int unsigned INFO_EN_BIT   = 7;
    localparam logic        INFO_EN_RST   = 1'b0;

    typedef enum logic [1:0] {
        PMD_SEL_NONE  = 2'b00,
        PMD_SEL_FLASH = 2'b01,
        PMD_SEL_INFO  = 2'b11
    } pmd_sel_e;

endpackage : pmd_pkg

// >>> src/pmd_info_rom.sv
`timescale 1ns/1ps
`default_nettype none

module pmd_info_rom #(
    parameter logic [159:0] PART_ID = {8'h50, 8'h4D, 8'h44, 8'h2D, 8'h44, 8'h45, 8'h4D,
                                       8'h4F, {12{8'hFF}}}
) (
    input  wire logic [6:0] idx,   // Byte index into the area.
    output logic      [7:0] data   // Byte at that index.
);

    logic [6:0] part_off;

    always_comb
    begin
        part_off = idx - 7'(pmd_pkg::PART_LO[6:0]);
        data     = pmd_pkg::BLANK_BYTE;
        if ({9'h1FC, idx} >= pmd_pkg::PART_LO && {9'h1FC, idx} <= pmd_pkg::PART_HI)
        begin
            data = PART_ID[159 - 8 * int'(part_off) -: 8]; // [RULE11]
        end
        else if ({9'h1FC, idx} <= pmd_pkg::INFO_OPT_HI ||
                 ({9'h1FC, idx} >= pmd_pkg::CAL_LO && {9'h1FC, idx} <= pmd_pkg::CAL_HI))
        begin
            data = pmd_pkg::BLANK_BYTE; // [RULE12]
        end
    end

endmodule : pmd_info_rom

`default_nettype wire

// >>> src/pmd_decoder.sv
// Summary of operation
// RULE1: Sixteen-bit address, flash from zero.
// RULE2: Flash size one to four kilobytes.
// RULE3: Reads beyond flash return all ones.
// RULE4: Writes beyond flash are ignored.
// RULE5: Fixed vector layout, code from 003E.
// RULE6: Data-memory accesses get no response.
// RULE7: Info area enabled by page bit seven.
// RULE8: Overlay covers FE00 through FF7F.
// RULE9: Overlay reads win over flash.
// RULE10: Info area is read-only.
// RULE11: Part identifier at FE40 to FE53.
// RULE12: Option and calibration ranges, rest reserved.
// RULE13: Enable bit clears on reset.
`timescale 1ns/1ps
`default_nettype none

module pmd_decoder #(
    parameter int unsigned FLASH_KB = pmd_pkg::FLASH_KB_DEF   // 1, 2 or 4.
) (
    input  wire logic        core_clk,     // System clock.
    input  wire logic        nrst,         // Asynchronous reset, active low.
    input  wire logic [15:0] cpu_addr,     // Program or data address.
    input  wire logic        cpu_rd,       // Program read strobe.
    input  wire logic        cpu_wr,       // Program write strobe.
    input  wire logic [7:0]  cpu_wdata,    // Write data.
    input  wire logic        cpu_data_sp,  // Access targets data memory space.
    input  wire logic        page_wr,      // Write strobe of page select register.
    input  wire logic [7:0]  page_wdata,   // Page select write data.
    input  wire logic [7:0]  flash_rdata,  // Flash array read data.
    output logic      [7:0]  cpu_rdata,    // Read data, one cycle after cpu_rd; two cycles after it for flash reads.
    output logic             cpu_rvalid,   // Read valid pulse, one cycle after cpu_rd; it leads flash read data by a cycle.
    output logic             info_en,      // Information area enabled.
    output logic      [15:0] flash_addr,   // Flash array address.
    output logic             flash_rd,     // Flash array read strobe.
    output logic             flash_wr,     // Flash array write strobe.
    output logic      [7:0]  flash_wdata,  // Flash array write data.
    output logic             vec_hit,      // Last access fell in the vector area.
    output logic             code_hit      // Last access fell in code storage.
);

    localparam logic [15:0] FLASH_TOP = 16'((FLASH_KB * 1024) - 1); // [RULE2]

    typedef struct packed {
        logic [7:0]  rdata;
        logic        rvalid;
        logic        info_en;
        logic [15:0] faddr;
        logic        frd;
        logic        fwr;
        logic [7:0]  fwdata;
        logic        vec;
        logic        code;
    } pmd_state_s;

    // Reset image of the whole state: all low except the idle read byte.
    localparam pmd_state_s ST_RST = '{
        rdata:   pmd_pkg::BLANK_BYTE,
        rvalid:  1'b0,
        info_en: pmd_pkg::INFO_EN_RST, // [RULE13]
        faddr:   16'h0000,
        frd:     1'b0,
        fwr:     1'b0,
        fwdata:  8'h00,
        vec:     1'b0,
        code:    1'b0
    };

    pmd_state_s st_reg;
    pmd_state_s st_next;
    logic [7:0] info_byte;

    // True for addresses inside the window that the overlay covers.
    function automatic logic pmd_in_window(input logic [15:0] a);
        return a >= pmd_pkg::INFO_LO && a <= pmd_pkg::INFO_HI; // [RULE8]
    endfunction : pmd_in_window

    // True for addresses in the fixed option and vector area.
    function automatic logic pmd_is_vec(input logic [15:0] a);
        return a < pmd_pkg::CODE_START; // [RULE5]
    endfunction : pmd_is_vec

    // The overlay is checked first so that it wins over flash and blank space.
    function automatic pmd_pkg::pmd_sel_e pmd_decode(input logic [15:0] a, input logic ov);
        if (ov && pmd_in_window(a))
        begin
            return pmd_pkg::PMD_SEL_INFO; // [RULE8] [RULE9]
        end
        else if (a <= FLASH_TOP)
        begin
            return pmd_pkg::PMD_SEL_FLASH; // [RULE1]
        end
        else
        begin
            return pmd_pkg::PMD_SEL_NONE;
        end
    endfunction : pmd_decode

    // The area is indexed straight from the bus, so its byte is ready in the
    // same cycle as the request and is registered with the valid pulse.
    pmd_info_rom u_info (
        .idx  (cpu_addr[6:0]),
        .data (info_byte)
    );

    always_comb
    begin
        pmd_pkg::pmd_sel_e sel;
        logic              rd_ok;
        logic              wr_ok;
        sel            = pmd_decode(cpu_addr, st_reg.info_en);
        rd_ok          = !cpu_data_sp && cpu_rd; // [RULE6]
        wr_ok          = !cpu_data_sp && cpu_wr; // [RULE6]
        st_next        = st_reg;
        st_next.rvalid = 1'b0;
        st_next.frd    = 1'b0;
        st_next.fwr    = 1'b0;
        if (page_wr)
        begin
            st_next.info_en = page_wdata[pmd_pkg::INFO_EN_BIT]; // [RULE7]
        end
        // The flash array answers in the cycle of its strobe; the byte is
        // captured at the end of that cycle and stands until the next read result.
        if (st_reg.frd)
        begin
            st_next.rdata = flash_rdata;
        end
        if (rd_ok || wr_ok)
        begin
            st_next.vec  = pmd_is_vec(cpu_addr); // [RULE5]
            st_next.code = !pmd_is_vec(cpu_addr) && sel == pmd_pkg::PMD_SEL_FLASH;
        end
        // A read wins over a write presented in the same cycle.
        if (rd_ok)
        begin
            st_next.rvalid = 1'b1;
            case (sel)
                pmd_pkg::PMD_SEL_FLASH:
                begin
                    st_next.faddr = cpu_addr; // [RULE2]
                    st_next.frd   = 1'b1;
                end
                pmd_pkg::PMD_SEL_INFO:
                begin
                    st_next.rdata = info_byte; // [RULE9]
                end
                default:
                begin
                    st_next.rdata = pmd_pkg::BLANK_BYTE; // [RULE3]
                end
            endcase
        end
        else if (wr_ok && sel == pmd_pkg::PMD_SEL_FLASH)
        begin
            // Writes outside flash, the overlay window included, never reach
            // the array, so the stored bytes cannot be disturbed.
            st_next.faddr  = cpu_addr; // [RULE4] [RULE10]
            st_next.fwr    = 1'b1;
            st_next.fwdata = cpu_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_reg <= ST_RST; // [RULE13]
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign cpu_rdata   = st_reg.rdata;
    assign cpu_rvalid  = st_reg.rvalid;
    assign info_en     = st_reg.info_en;
    assign flash_addr  = st_reg.faddr;
    assign flash_rd    = st_reg.frd;
    assign flash_wr    = st_reg.fwr;
    assign flash_wdata = st_reg.fwdata;
    assign vec_hit     = st_reg.vec;
    assign code_hit    = st_reg.code;

endmodule : pmd_decoder

`default_nettype wire

// >>> test/pmd_decoder_props.sv
`timescale 1ns/1ps
`default_nettype none
module pmd_decoder_props #(
    parameter int unsigned FLASH_KB = 4  // Flash size in kilobytes.
) (
    input wire logic        core_clk,    // Clock.
    input wire logic        nrst,        // Reset, active low.
    input wire logic [15:0] cpu_addr,    // Address.
    input wire logic        cpu_rd,      // Read.
    input wire logic        cpu_wr,      // Write.
    input wire logic        cpu_data_sp, // Data space.
    input wire logic        page_wr,     // Page write.
    input wire logic [7:0]  page_wdata,  // Page data.
    input wire logic [7:0]  cpu_rdata,   // Read data.
    input wire logic        cpu_rvalid,  // Read valid.
    input wire logic        info_en,     // Overlay on.
    input wire logic [15:0] flash_addr,  // Flash address.
    input wire logic        flash_rd,    // Flash read.
    input wire logic        flash_wr     // Flash write.
);
    localparam logic [15:0] TOP = 16'(FLASH_KB * 1024 - 1);
    logic ok, win;
    assign ok  = !cpu_data_sp;
    assign win = cpu_addr >= 16'hFE00 && cpu_addr <= 16'hFF7F;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_read_valid: assert property (cpu_rd && ok |=> cpu_rvalid)
        else $error("read not answered");
    a_data_quiet: assert property (cpu_data_sp |=> !cpu_rvalid && !flash_rd && !flash_wr)
        else $error("data space access answered");
    a_wr_beyond: assert property (cpu_wr && !cpu_rd && ok && cpu_addr > TOP |=> !flash_wr)
        else $error("write beyond flash passed on");
    a_rd_blank: assert property (cpu_rd && ok && cpu_addr > TOP && !(info_en && win)
        |=> cpu_rdata == 8'hFF && !flash_rd)
        else $error("unmapped read not blank");
    a_flash_fetch: assert property (cpu_rd && ok && cpu_addr <= TOP
        |=> flash_rd && flash_addr == $past(cpu_addr))
        else $error("flash read not issued");
    a_info_ro: assert property (cpu_wr && !cpu_rd && ok && info_en && win |=> !flash_wr)
        else $error("write into info window passed on");
    a_info_wins: assert property (cpu_rd && ok && info_en && win |=> !flash_rd)
        else $error("flash read inside overlay");
    a_enable_bit: assert property (page_wr |=> info_en == $past(page_wdata[7]))
        else $error("enable bit not taken");
endmodule : pmd_decoder_props
bind pmd_decoder pmd_decoder_props #(.FLASH_KB(FLASH_KB)) u_props (.core_clk(core_clk),
    .nrst(nrst), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
    .cpu_data_sp(cpu_data_sp), .page_wr(page_wr), .page_wdata(page_wdata),
    .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .info_en(info_en),
    .flash_addr(flash_addr), .flash_rd(flash_rd), .flash_wr(flash_wr));
`default_nettype wire

// >>> test/pmd_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmd_flash_model #(
    parameter int unsigned FLASH_KB = 4  // Flash size in kilobytes.
) (
    input wire logic        core_clk,    // Clock.
    input wire logic [15:0] flash_addr,  // Address.
    input wire logic        flash_rd,    // Read strobe.
    input wire logic        flash_wr,    // Write strobe.
    input wire logic [7:0]  flash_wdata, // Write data.
    output logic     [7:0]  flash_rdata  // Read data.
);
    localparam int N = FLASH_KB * 1024;
    logic [7:0]  mem [N];
    logic [15:0] ra  = '0;
    logic        vld = 1'b0;
    initial for (int i = 0; i < N; i++) mem[i] = 8'(i) ^ 8'hA5;
    // Index wraps, so a stray write beyond the top corrupts a low byte.
    always @(posedge core_clk)
    begin
        vld <= flash_rd;
        if (flash_rd) ra <= flash_addr;
        if (flash_wr) mem[int'(flash_addr) % N] <= flash_wdata;
    end
    // Outside the valid cycles the bus shows the inverse of the stored byte.
    assign flash_rdata = flash_rd ? mem[int'(flash_addr) % N]
                       : vld ? mem[int'(ra) % N] : ~mem[int'(ra) % N];
endmodule : pmd_flash_model
`default_nettype wire

// >>> test/program_memory_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module program_memory_decoder_tb;
    logic core_clk = 0, nrst = 1, cpu_rd = 0, cpu_wr = 0, cpu_data_sp = 0, page_wr = 0;
    logic [15:0] cpu_addr = '0;
    logic [7:0]  cpu_wdata = '0, page_wdata = '0;
    wire logic [7:0]  flash_rdata, cpu_rdata, flash_wdata;
    wire logic [15:0] flash_addr;
    wire logic cpu_rvalid, info_en, flash_rd, flash_wr, vec_hit, code_hit;
    int fails = 0, num_checks = 0;
    always #2.5 core_clk = ~core_clk;
    pmd_decoder #(.FLASH_KB(1)) dut (.core_clk(core_clk), .nrst(nrst), .cpu_addr(cpu_addr),
        .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_data_sp(cpu_data_sp),
        .page_wr(page_wr), .page_wdata(page_wdata), .flash_rdata(flash_rdata),
        .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .info_en(info_en),
        .flash_addr(flash_addr), .flash_rd(flash_rd), .flash_wr(flash_wr),
        .flash_wdata(flash_wdata), .vec_hit(vec_hit), .code_hit(code_hit));
    pmd_flash_model #(.FLASH_KB(1)) u_flash (.core_clk(core_clk), .flash_addr(flash_addr),
        .flash_rd(flash_rd), .flash_wr(flash_wr), .flash_wdata(flash_wdata),
        .flash_rdata(flash_rdata));
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task rd(input logic [15:0] a, input logic [7:0] exp);
        cpu_addr = a;
        cpu_rd = 1;
        @(negedge core_clk) cpu_rd = 0;
        chk({7'h0, cpu_rvalid}, {7'h0, !cpu_data_sp});
        @(negedge core_clk) if (!cpu_data_sp) chk(cpu_rdata, exp);
    endtask : rd
    task wr(input logic [15:0] a, input logic [7:0] d);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1;
        @(negedge core_clk) cpu_wr = 0;
        @(negedge core_clk);
    endtask : wr
    task pg(input logic [7:0] d, input logic exp);
        page_wdata = d;
        page_wr = 1;
        @(negedge core_clk) page_wr = 0;
        chk({7'h0, info_en}, {7'h0, exp});
    endtask : pg
    task t_flash;
        rd(16'h0002, 8'hA7);
        chk({6'h0, vec_hit, code_hit}, 8'h02);
        rd(16'h003E, 8'h9B);
        chk({6'h0, vec_hit, code_hit}, 8'h01);
        rd(16'h03FF, 8'h5A);
        rd(16'h0400, 8'hFF);
        rd(16'hFFFF, 8'hFF);
        wr(16'h0100, 8'h3C);
        rd(16'h0100, 8'h3C);
        wr(16'h0400, 8'h11);
        rd(16'h0000, 8'hA5);
        cpu_data_sp = 1;
        rd(16'h0001, 8'h00);
        cpu_data_sp = 0;
    endtask : t_flash
    task t_info;
        rd(16'hFE40, 8'hFF);
        pg(8'h80, 1'b1);
        rd(16'hFE40, 8'h50);
        rd(16'hFE47, 8'h4F);
        rd(16'hFE53, 8'hFF);
        rd(16'hFE00, 8'hFF);
        rd(16'hFE54, 8'hFF);
        rd(16'hFF7F, 8'hFF);
        wr(16'hFE00, 8'h12);
        rd(16'hFE00, 8'hFF);
        rd(16'h0200, 8'hA5);
        pg(8'h7F, 1'b0);
    endtask : t_info
    initial
    begin
        #20000 fails++;
        stop_test();
    end
    initial
    begin
        #1 nrst = 0;
        repeat (2) @(negedge core_clk);
        chk({7'h0, info_en}, 8'h00);
        chk(cpu_rdata, 8'hFF);
        nrst = 1;
        @(negedge core_clk);
        t_flash();
        t_info();
        stop_test();
    end
endmodule : program_memory_decoder_tb
`default_nettype wire
